/* File: acc_pkg.sv */
// Package for the analog comparator control block: offsets, fields, types.
// Assumes an 8-bit register port addressed with the printed offsets.
package acc_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_CTRL_A = 8'h08;
   localparam logic [7:0] OFS_CTRL_B = 8'h09;
   // Register A field positions
   localparam int A_POWER_OFF = 7;
   localparam int A_BANDGAP = 6;
   localparam int A_RESULT = 5;
   localparam int A_FLAG = 4;
   localparam int A_IRQ_EN = 3;
   localparam int A_MUX_EN = 2;
   // Register B field positions
   localparam int B_HYST_EN = 7;
   localparam int B_HYST_LEVEL = 6;
   // Reset values of the writable fields
   localparam logic [7:0] RST_CTRL_A = 8'h00;
   localparam logic [7:0] RST_CTRL_B = 8'h00;
   // Highest converter channel code that reaches the comparator
   localparam logic [5:0] CHAN_MAX = 6'h0A;
   // Interrupt mode codes
   localparam logic [1:0] MODE_TOGGLE = 2'h0;
   localparam logic [1:0] MODE_FALL = 2'h2;
   localparam logic [1:0] MODE_RISE = 2'h3;
   // Analog source codes for the comparator inputs
   typedef enum logic [3:0] {
      ACC_SRC_PIN0, ACC_SRC_PIN1, ACC_SRC_PIN2, ACC_SRC_BANDGAP, ACC_SRC_CONV
   } acc_src_t;
   // Analog front-end controls travel together
   typedef struct packed {
      logic power_off;
      acc_src_t pos_src;
      acc_src_t neg_src;
      logic [5:0] conv_channel;
      logic hyst_en;
      logic hyst_50mv;
   } acc_analog_t;
endpackage

/* File: acc_ctrl.sv */
// Analog comparator control: input routing, result sync, edge flag, irq.
// Assumes the analog comparator output arrives asynchronously on I_CMP_RAW.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
// Operation
// R01: Result bit is high when positive input exceeds negative; software cannot write it.
// R02: Raw comparator output is synchronised, one to two clocks of latency.
// R03: Flag bit 4 of register A sets on the selected edge event.
// R04: Flag clears when the processor acknowledges the interrupt vector.
// R05: Writing one to the flag clears it; zero leaves it.
// R06: Interrupt requested only with flag, enable bit 3 and global enable set.
// R07: Mode 00 toggle, 01 reserved, 10 falling, 11 rising.
// R08: Bit 7 written one powers the comparator off; zero keeps it on.
// R09: Software disables the interrupt before changing power or mode bits.
// R10: Bandgap bit 6 routes 1.1V reference to the positive input.
// R11: Mux enable with converter off takes negative input from converter channel 0-10.
// R12: Otherwise the three-bit field picks the positive/negative pin pair.
// R13: With converter channel negative, field picks positive pin: 000, 01x, 1xx.
// R14: Register B bit 7 enables hysteresis; bit 6 selects 20mV or 50mV.
// R15: Converter enable input is the converter's own enable control.
// R16: Mux enable lives in bit 2 of register A.
module acc_ctrl
   import acc_pkg::*;
(
   input wire logic I_CLOCK,
   input wire logic I_RST_N,
   input wire logic [ADDR_W-1:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic I_CMP_RAW,
   input wire logic I_CONVERTER_ENABLE,
   input wire logic [5:0] I_CONVERTER_CHANNEL_FIELD,
   input wire logic I_GLOBAL_IRQ_ENABLE,
   input wire logic I_IRQ_ACK,
   output logic [7:0] O_RDATA,
   output logic O_IRQ,
   output acc_analog_t O_ANALOG
);
   // Control state
   logic power_off;
   logic bandgap;
   logic irq_en;
   logic mux_en;
   logic [1:0] mode;
   logic hyst_en;
   logic hyst_level;
   logic [2:0] pair_sel;
   logic flag;
   logic sync1;
   logic sync2;
   logic prev;

   // Register decode
   wire sel_a = (I_ADDR == OFS_CTRL_A);
   wire sel_b = (I_ADDR == OFS_CTRL_B);
   wire wr_a = I_WR && sel_a;
   wire wr_b = I_WR && sel_b;
   wire [7:0] reg_a = {power_off, bandgap, sync2, flag, irq_en, mux_en, mode};
   wire [7:0] reg_b = {hyst_en, hyst_level, 3'h0, pair_sel};
   wire [7:0] rd_mux = sel_a ? reg_a : (sel_b ? reg_b : 8'h00);

   // Edge detection on the synchronised result
   wire rise = sync2 && !prev;
   wire fall = !sync2 && prev;
   wire event_hit = (mode == MODE_TOGGLE) ? (rise || fall) : // R07
                    (mode == MODE_FALL) ? fall :
                    (mode == MODE_RISE) ? rise : 1'b0;
   wire flag_clr = I_IRQ_ACK || (wr_a && I_WDATA[A_FLAG]); // R04 R05
   wire next_flag = event_hit ? 1'b1 : (flag_clr ? 1'b0 : flag); // R03
   wire next_irq = next_flag && irq_en && I_GLOBAL_IRQ_ENABLE; // R06

   // Input routing
   wire conv_neg = mux_en && !I_CONVERTER_ENABLE; // R11 R15 R16

   function automatic acc_src_t pair_pos(input logic [2:0] s);
      if (s[2]) pair_pos = ACC_SRC_PIN2;
      else if (s[1]) pair_pos = ACC_SRC_PIN1;
      else pair_pos = ACC_SRC_PIN0;
   endfunction

   function automatic acc_src_t pair_neg(input logic [2:0] s);
      case (s)
         3'h0: pair_neg = ACC_SRC_PIN1;
         3'h1: pair_neg = ACC_SRC_PIN2;
         3'h2: pair_neg = ACC_SRC_PIN0;
         3'h3: pair_neg = ACC_SRC_PIN2;
         3'h4: pair_neg = ACC_SRC_PIN0;
         default: pair_neg = ACC_SRC_PIN1;
      endcase
   endfunction

   // Positive pin: 000->0, 01x->1, 1xx->2; 001 in pin mode is pin0 as well
   wire acc_src_t pos_pin = pair_pos(pair_sel); // R12 R13
   wire acc_src_t next_pos = bandgap ? ACC_SRC_BANDGAP : pos_pin; // R10
   wire acc_src_t next_neg = conv_neg ? ACC_SRC_CONV : pair_neg(pair_sel); // R11 R12
   wire [5:0] next_chan = (I_CONVERTER_CHANNEL_FIELD <= CHAN_MAX) ?
                          I_CONVERTER_CHANNEL_FIELD : 6'h00;
   acc_analog_t next_analog;
   always_comb begin
      next_analog.power_off = power_off; // R08
      next_analog.pos_src = next_pos;
      next_analog.neg_src = next_neg;
      next_analog.conv_channel = next_chan;
      next_analog.hyst_en = hyst_en; // R14
      next_analog.hyst_50mv = hyst_level;
   end

   // Synchroniser for the raw comparator output
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         prev <= 1'b0;
      end else begin
         sync1 <= I_CMP_RAW; // R02
         sync2 <= sync1; // R01
         prev <= sync2;
      end
   end

   // Register A writable fields
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         {power_off, bandgap} <= RST_CTRL_A[7:6];
         {irq_en, mux_en, mode} <= RST_CTRL_A[3:0];
      end else if (wr_a) begin
         power_off <= I_WDATA[A_POWER_OFF]; // R08
         bandgap <= I_WDATA[A_BANDGAP];
         irq_en <= I_WDATA[A_IRQ_EN];
         mux_en <= I_WDATA[A_MUX_EN]; // R16
         mode <= I_WDATA[1:0];
      end
   end

   // Register B writable fields
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         {hyst_en, hyst_level} <= RST_CTRL_B[7:6];
         pair_sel <= RST_CTRL_B[2:0];
      end else if (wr_b) begin
         hyst_en <= I_WDATA[B_HYST_EN]; // R14
         hyst_level <= I_WDATA[B_HYST_LEVEL];
         pair_sel <= I_WDATA[2:0];
      end
   end

   // Flag, request and read data
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         flag <= 1'b0;
         O_IRQ <= 1'b0;
         O_RDATA <= 8'h00;
      end else begin
         flag <= next_flag; // R03
         O_IRQ <= next_irq; // R06
         O_RDATA <= I_RD ? rd_mux : 8'h00;
      end
   end

   // Analog controls from flops
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_ANALOG <= '0;
      end else begin
         O_ANALOG <= next_analog;
      end
   end

   // Checks
   AST_RESULT_LAT: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R02
      ##2 (sync2 == $past(I_CMP_RAW, 2)))
      else $error("result not two cycles behind raw input");
   AST_RISE_FLAG: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R03
      (mode == MODE_RISE && rise) |=> flag)
      else $error("rising edge did not set flag");
   AST_RESERVED: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R07
      (mode == 2'h1 && !flag && !wr_a) |=> !flag)
      else $error("reserved mode set flag");
   AST_ACK_CLR: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R04
      (I_IRQ_ACK && !event_hit) |=> !flag)
      else $error("ack did not clear flag");
   AST_W1C: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R05
      (wr_a && !I_WDATA[A_FLAG] && !I_IRQ_ACK && flag) |=> flag)
      else $error("zero write cleared flag");
   AST_IRQ: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R06
      O_IRQ |-> ($past(irq_en) || $past(wr_a)) && $past(I_GLOBAL_IRQ_ENABLE))
      else $error("request without enables");
   AST_BANDGAP: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R10
      bandgap |=> O_ANALOG.pos_src == ACC_SRC_BANDGAP || $past(wr_a))
      else $error("bandgap not routed");
   AST_CONV_NEG: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R11
      (mux_en && !I_CONVERTER_ENABLE) |=> O_ANALOG.neg_src == ACC_SRC_CONV || $past(wr_a))
      else $error("converter channel not on negative input");
   AST_POWER: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R08
      O_ANALOG.power_off == $past(power_off))
      else $error("power control mismatch");
   // Edge selection: each mode sets the flag on its own event only
   AST_FALL_FLAG: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R03
      (mode == MODE_FALL && fall) |=> flag)
      else $error("falling edge did not set flag");
   AST_TOGGLE_FLAG: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R07
      (mode == MODE_TOGGLE && (rise || fall)) |=> flag)
      else $error("toggle did not set flag");
   AST_RISE_ONLY: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R07
      (mode == MODE_RISE && !rise && !flag) |=> !flag)
      else $error("rise mode set flag without rising edge");
   AST_FALL_ONLY: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R07
      (mode == MODE_FALL && !fall && !flag) |=> !flag)
      else $error("fall mode set flag without falling edge");

   // Flag holds until cleared; a set in the clear cycle wins
   AST_FLAG_HOLD: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R03
      (flag && !I_IRQ_ACK && !(wr_a && I_WDATA[A_FLAG])) |=> flag)
      else $error("flag dropped without a clear");
   AST_W1C_CLR: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R05
      (wr_a && I_WDATA[A_FLAG] && !event_hit) |=> !flag)
      else $error("write one did not clear flag");
   AST_SET_WINS: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R03
      (event_hit && (I_IRQ_ACK || (wr_a && I_WDATA[A_FLAG]))) |=> flag)
      else $error("clear beat a simultaneous set");

   // Request gating by the two enables, and request clearing on acknowledge
   AST_IRQ_OFF_EN: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R06
      !irq_en |=> !O_IRQ)
      else $error("request with interrupt enable clear");
   AST_IRQ_OFF_GIE: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R06
      !I_GLOBAL_IRQ_ENABLE |=> !O_IRQ)
      else $error("request with global enable clear");
   AST_IRQ_ON: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R06
      (flag && irq_en && I_GLOBAL_IRQ_ENABLE && !I_IRQ_ACK && !(wr_a && I_WDATA[A_FLAG]))
      |=> O_IRQ)
      else $error("request missing with flag and enables set");
   AST_ACK_IRQ: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R04
      (I_IRQ_ACK && !event_hit) |=> !O_IRQ)
      else $error("request stayed after acknowledge");

   // Read port: result bit, reserved bits and idle data
   AST_RESULT_READ: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R01
      (I_RD && sel_a) |=> O_RDATA[A_RESULT] == $past(sync2))
      else $error("result bit read wrong");
   AST_RDATA_IDLE: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R01
      !I_RD |=> O_RDATA == 8'h00)
      else $error("read data not zero outside read");
   AST_RD_B_ZERO: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R14
      (I_RD && sel_b) |=> O_RDATA[5:3] == 3'h0)
      else $error("unused bits of register B not zero");
   AST_RESULT_RO: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R01
      wr_a |=> sync2 == $past(sync1))
      else $error("write reached the result bit");

   // Input routing seen on the analog controls
   AST_POS_PIN0: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R12
      (!bandgap && pair_sel[2:1] == 2'h0) |=> O_ANALOG.pos_src == ACC_SRC_PIN0)
      else $error("positive input not pin zero");
   AST_POS_PIN1: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R13
      (!bandgap && pair_sel[2:1] == 2'h1) |=> O_ANALOG.pos_src == ACC_SRC_PIN1)
      else $error("positive input not pin one");
   AST_POS_PIN2: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R13
      (!bandgap && pair_sel[2]) |=> O_ANALOG.pos_src == ACC_SRC_PIN2)
      else $error("positive input not pin two");
   AST_NEG_PIN: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R12
      !mux_en |=> O_ANALOG.neg_src != ACC_SRC_CONV)
      else $error("converter channel used with mux disabled");
   AST_NEG_HIGH: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R12
      (!conv_neg && pair_sel >= 3'h5) |=> O_ANALOG.neg_src == ACC_SRC_PIN1)
      else $error("upper pair codes not on pin one");
   AST_CONV_ON: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R15
      I_CONVERTER_ENABLE |=> O_ANALOG.neg_src != ACC_SRC_CONV)
      else $error("converter channel used while converter on");
   AST_CHAN: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R11
      (I_CONVERTER_CHANNEL_FIELD <= CHAN_MAX)
      |=> O_ANALOG.conv_channel == $past(I_CONVERTER_CHANNEL_FIELD))
      else $error("converter channel not passed on");
   AST_CHAN_CLAMP: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R11
      (I_CONVERTER_CHANNEL_FIELD > CHAN_MAX) |=> O_ANALOG.conv_channel == 6'h00)
      else $error("out of range channel not forced to zero");

   // Register writes land in their fields; hysteresis fields reach the analog controls
   AST_MUX_WR: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R16
      wr_a |=> mux_en == $past(I_WDATA[A_MUX_EN]))
      else $error("mux enable not written from bit 2");
   AST_POWER_WR: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R08
      wr_a |=> power_off == $past(I_WDATA[A_POWER_OFF]))
      else $error("power bit not written");
   AST_HYST_WR: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R14
      wr_b |=> hyst_en == $past(I_WDATA[B_HYST_EN]) && hyst_level == $past(I_WDATA[B_HYST_LEVEL]))
      else $error("hysteresis fields not written");
   AST_HYST: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R14
      O_ANALOG.hyst_en == $past(hyst_en) && O_ANALOG.hyst_50mv == $past(hyst_level))
      else $error("hysteresis controls mismatch");

   // Main scenarios reached
   COV_TOGGLE: cover property (@(posedge I_CLOCK) mode == MODE_TOGGLE && fall ##1 flag);
   COV_IRQ: cover property (@(posedge I_CLOCK) O_IRQ ##[1:8] I_IRQ_ACK);
   COV_CONV: cover property (@(posedge I_CLOCK) O_ANALOG.neg_src == ACC_SRC_CONV);
   COV_W1C: cover property (@(posedge I_CLOCK) wr_a && I_WDATA[A_FLAG] && flag);
   COV_BANDGAP: cover property (@(posedge I_CLOCK) O_ANALOG.pos_src == ACC_SRC_BANDGAP);
endmodule

/* File: acc_analog_model.sv */
// Far-side model: pin and converter channel levels feeding the comparator.
// Assumes the bench sets each source level; channels follow the fixed sources.
`timescale 1ns/10ps
module acc_analog_model
   import acc_pkg::*;
(
   input wire acc_analog_t i_analog,
   input wire logic [7:0] i_level [0:15],
   output logic o_cmp_raw
);
   // Level of one selected source
   function automatic logic [7:0] lvl(input logic [3:0] s, input logic [5:0] ch);
      return (s == ACC_SRC_CONV) ? i_level[4'h4 + ch[3:0]] : i_level[s];
   endfunction
   // Output held low while powered off
   assign o_cmp_raw = !i_analog.power_off &&
      (lvl(i_analog.pos_src, i_analog.conv_channel) >
       lvl(i_analog.neg_src, i_analog.conv_channel));
endmodule

/* File: analog_comparator_control_bench.sv */
// Bench for acc_ctrl: register port, input routing, edge flag and request.
// Assumes acc_analog_model drives the raw comparator output.
`timescale 1ns/10ps
module analog_comparator_control_bench;
   import acc_pkg::*;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, cen = 0, gie = 0, ack = 0, raw, irq, rd_seen = 0;
   logic [7:0] addr = 0, wdata = 0, rdata, h;
   logic [5:0] chan = 0;
   logic [7:0] lv [0:15] = '{default: 8'h00};
   logic [31:0] rs = 78771;
   logic [15:0] q [$];
   acc_analog_t ana;
   int n_fail = 0, n_compared = 0, cyc = 0;
   // Clock, 40 ns period
   always #20 clk = ~clk;
   acc_ctrl dut_u (.I_CLOCK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
      .I_RD(rd), .I_CMP_RAW(raw), .I_CONVERTER_ENABLE(cen), .I_CONVERTER_CHANNEL_FIELD(chan),
      .I_GLOBAL_IRQ_ENABLE(gie), .I_IRQ_ACK(ack), .O_RDATA(rdata), .O_IRQ(irq), .O_ANALOG(ana));
   acc_analog_model far_u (.i_analog(ana), .i_level(lv), .o_cmp_raw(raw));
   function automatic logic [7:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs[7:0];
   endfunction
   task automatic print_verdict();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] s);
      n_compared++;
      if (e !== s) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read, noting expected value and mask
   task automatic bus_rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      q.push_back({m, e});
      @(posedge clk);
      rd <= 1'b0;
   endtask
   task automatic chk_ana(input logic [3:0] p, input logic [3:0] n, input logic [2:0] f);
      repeat (2) @(negedge clk);
      cmp("pos", {4'h0, p}, {4'h0, ana.pos_src});
      cmp("neg", {4'h0, n}, {4'h0, ana.neg_src});
      cmp("flags", {5'h0, f}, {5'h0, ana.power_off, ana.hyst_en, ana.hyst_50mv});
   endtask
   task automatic chk_irq(input logic e);
      repeat (2) @(negedge clk);
      cmp("irq", {7'h0, e}, {7'h0, irq});
   endtask
   // Positive pin above or below the negative pin, then settle
   task automatic lvl(input logic up);
      @(posedge clk);
      lv[0] <= up ? lv[1] + 8'h01 : 8'h00;
      repeat (6) @(posedge clk);
   endtask
   // Read results checked mid-cycle against the oldest note; hang guard
   always @(posedge clk) begin
      rd_seen <= rd;
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         print_verdict();
      end
   end
   always @(negedge clk) if (rd_seen) begin
      cmp("read", q[0][7:0] & q[0][15:8], rdata & q[0][15:8]);
      void'(q.pop_front());
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      bus_rd(OFS_CTRL_A, 8'h00, 8'hDF);
      bus_rd(OFS_CTRL_B, 8'h00, 8'hFF);
      bus_rd(8'h0A, 8'h00, 8'hFF);
      for (int c = 0; c < 8; c++) begin
         h = rnd();
         bus_wr(OFS_CTRL_B, {h[1:0], 3'h0, 3'(c)});
         bus_rd(OFS_CTRL_B, {h[1:0], 3'h0, 3'(c)}, 8'hFF);
         chk_ana(4'((c < 2) ? 0 : (c < 4) ? 1 : 2),
            4'((c == 0 || c > 4) ? 1 : (c == 2 || c == 4) ? 0 : 2), {1'b0, h[1:0]});
      end
      @(posedge clk);
      cen <= 1'b1;
      bus_wr(OFS_CTRL_A, 8'h04);
      bus_wr(OFS_CTRL_B, 8'h00);
      chk_ana(ACC_SRC_PIN0, ACC_SRC_PIN1, 3'h0);
      @(posedge clk);
      cen <= 1'b0;
      for (int c = 0; c < 11; c++) begin
         h = rnd();
         @(posedge clk);
         chan <= 6'(c);
         bus_wr(OFS_CTRL_B, {5'h0, h[2:0]});
         chk_ana(h[2] ? ACC_SRC_PIN2 : h[1] ? ACC_SRC_PIN1 : ACC_SRC_PIN0, ACC_SRC_CONV, 3'h0);
         cmp("chan", 8'(c), {2'h0, ana.conv_channel});
      end
      @(posedge clk);
      chan <= 6'h0B | 6'(rnd());
      repeat (2) @(negedge clk);
      cmp("chan", 8'h00, {2'h0, ana.conv_channel});
      bus_wr(OFS_CTRL_B, 8'h00);
      bus_wr(OFS_CTRL_A, 8'h40);
      chk_ana(ACC_SRC_BANDGAP, ACC_SRC_PIN1, 3'h0);
      bus_wr(OFS_CTRL_A, 8'h80);
      chk_ana(ACC_SRC_PIN0, ACC_SRC_PIN1, 3'h4);
      lv[1] <= rnd() & 8'h7F;
      for (int m = 0; m < 4; m++) begin
         bus_wr(OFS_CTRL_A, 8'h10 | 8'(m));
         lvl(1'b1);
         bus_rd(OFS_CTRL_A, {2'h0, 1'b1, m == 0 || m == 3, 2'h0, 2'(m)}, 8'hFF);
         bus_wr(OFS_CTRL_A, 8'h10 | 8'(m));
         lvl(1'b0);
         bus_rd(OFS_CTRL_A, {3'h0, m == 0 || m == 2, 2'h0, 2'(m)}, 8'hFF);
      end
      gie <= 1'b1;
      bus_wr(OFS_CTRL_A, 8'h1B);
      lvl(1'b1);
      chk_irq(1'b1);
      bus_wr(OFS_CTRL_A, 8'h0B);
      bus_rd(OFS_CTRL_A, 8'h3B, 8'hFF);
      @(posedge clk);
      gie <= 1'b0;
      chk_irq(1'b0);
      @(posedge clk);
      gie <= 1'b1;
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      chk_irq(1'b0);
      bus_rd(OFS_CTRL_A, 8'h2B, 8'hFF);
      repeat (4) @(posedge clk);
      print_verdict();
   end
endmodule
